// *** pcc_params.svh ***
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

`define PCC_ADDR_PIN_CTRL 16'h801A
`define PCC_ADDR_RX_CNT_B3 16'h801B
`define PCC_ADDR_RX_CNT_B2 16'h801C
`define PCC_ADDR_RX_CNT_B1 16'h801D
`define PCC_ADDR_RX_CNT_B0 16'h801E
`define PCC_ADDR_TX_CNT_B3 16'h801F
`define PCC_ADDR_TX_CNT_B2 16'h8020
`define PCC_ADDR_TX_CNT_B1 16'h8021
`define PCC_ADDR_TX_CNT_B0 16'h8022
`define PCC_ADDR_RX_SUBPORT_CFG2 16'h8023
`define PCC_ADDR_SUBPORT_CFG1 16'h8013
`define PCC_ADDR_TX_SUBPORT_POS 16'h8015
`define PCC_ADDR_RX_SUBPORT_POS 16'h8024

`define PCC_BIT_OVERRIDE 0
`define PCC_BIT_STRAP_FIRST 1
`define PCC_BIT_STRAP_SECOND 2
`define PCC_BIT_EE_MUX 3
`define PCC_BIT_EE_CLK 4
`define PCC_BIT_EE_CS_N 5
`define PCC_BIT_EE_DOUT 6
`define PCC_BIT_EE_DIN 7

`define PCC_RST_PIN_CTRL 8'h00
`define PCC_RST_COUNT 32'h0000_0000
`define PCC_RST_WIDTH 3'h5
`define PCC_RST_BIT_LOC 3'h5
`define PCC_RST_SUBPORT 5'h00

`endif

// *** pcc_pkg.sv ***
package pcc_pkg;

  typedef struct packed {
    logic clk;
    logic cs_n;
    logic dout;
  } pcc_ee_drive_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pcc_reg_req_t;

endpackage

// *** pcc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module pcc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // raw input and filtered result
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once the second and third stage agree
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        q_o[g] <= 1'b0;
      end else if (s2_q[g] == s3_q[g]) begin
        q_o[g] <= s3_q[g];
      end
    end
  end

endmodule // pcc_sync

`default_nettype wire

// *** pcc_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pcc_params.svh"

module pcc_regs #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // in-band register access
  input wire pcc_pkg::pcc_reg_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // strap pins
  input wire logic strap_input_first_i,
  input wire logic strap_input_second_i,
  input wire logic [2:0] strap_tx_byte_loc_i,
  input wire logic [2:0] strap_rx_byte_loc_i,
  // cell completion pulses from the multi-phy bus
  input wire logic rx_cell_done_i,
  input wire logic tx_cell_done_i,
  // internal loader eeprom drive
  input wire pcc_pkg::pcc_ee_drive_t loader_ee_i,
  output logic loader_ee_din_o,
  // eeprom pins
  output logic ee_clk_o,
  output logic ee_cs_n_o,
  output logic ee_dout_o,
  input wire logic ee_din_i,
  // configuration to datapath
  output logic [2:0] rx_subport_width_o,
  output logic [2:0] tx_subport_width_o,
  output logic [2:0] tx_byte_loc_o,
  output logic [2:0] rx_byte_loc_o
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] strap_s;
  logic ee_din_s;
  logic [2:0] strap_tx_loc_s;
  logic [2:0] strap_rx_loc_s;

  // byte location straps settle by the fourth edge, ahead of the load
  pcc_sync #(.W(9)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({strap_rx_byte_loc_i, strap_tx_byte_loc_i, ee_din_i, strap_input_second_i,
          strap_input_first_i}),
    .q_o({strap_rx_loc_s, strap_tx_loc_s, ee_din_s, strap_s})
  );

  //////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release

  logic [2:0] cap_cnt_q;
  logic strap_done_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cap_cnt_q <= 3'h0;
    end else if (!strap_done_q) begin
      cap_cnt_q <= cap_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_done_q <= 1'b0;
    end else if (cap_cnt_q == 3'h4) begin
      strap_done_q <= 1'b1;
    end
  end

  wire strap_load = (cap_cnt_q == 3'h4) && !strap_done_q;

  //////////////////////////////////////////////////////////////////////////////
  // pin-control register

  logic override_q;
  logic [1:0] strap_q;
  logic ee_mux_q;
  logic ee_clk_sw_q;
  logic ee_cs_n_sw_q;
  logic ee_dout_sw_q;
  logic ee_din_q;

  wire wr_pin = req_i.wr && (req_i.addr == `PCC_ADDR_PIN_CTRL);
  wire wr_cfg2 = req_i.wr && (req_i.addr == `PCC_ADDR_RX_SUBPORT_CFG2);
  wire wr_cfg1 = req_i.wr && (req_i.addr == `PCC_ADDR_SUBPORT_CFG1);
  wire wr_txpos = req_i.wr && (req_i.addr == `PCC_ADDR_TX_SUBPORT_POS);
  wire wr_rxpos = req_i.wr && (req_i.addr == `PCC_ADDR_RX_SUBPORT_POS);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      override_q <= 1'b0;
      ee_mux_q <= 1'b0;
      ee_clk_sw_q <= 1'b0;
      ee_cs_n_sw_q <= 1'b0;
      ee_dout_sw_q <= 1'b0;
    end else if (wr_pin) begin
      override_q <= req_i.wdata[`PCC_BIT_OVERRIDE];
      ee_mux_q <= req_i.wdata[`PCC_BIT_EE_MUX];
      ee_clk_sw_q <= req_i.wdata[`PCC_BIT_EE_CLK];
      ee_cs_n_sw_q <= req_i.wdata[`PCC_BIT_EE_CS_N];
      ee_dout_sw_q <= req_i.wdata[`PCC_BIT_EE_DOUT];
    end
  end

  // strap levels kept live from the filtered pins
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_q <= 2'b00;
    end else begin
      strap_q <= strap_s;
    end
  end

  // returned serial data is shown only under software control
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ee_din_q <= 1'b0;
    end else begin
      ee_din_q <= ee_mux_q ? ee_din_s : 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loader_ee_din_o <= 1'b0;
    end else begin
      loader_ee_din_o <= ee_din_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // eeprom pin mux

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ee_clk_o <= 1'b0;
      ee_cs_n_o <= 1'b1;
      ee_dout_o <= 1'b0;
    end else if (ee_mux_q) begin
      ee_clk_o <= ee_clk_sw_q;
      ee_cs_n_o <= ee_cs_n_sw_q;
      ee_dout_o <= ee_dout_sw_q;
    end else begin
      ee_clk_o <= loader_ee_i.clk;
      ee_cs_n_o <= loader_ee_i.cs_n;
      ee_dout_o <= loader_ee_i.dout;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // cell counters

  logic [CNT_W-1:0] rx_cnt_q;
  logic [CNT_W-1:0] tx_cnt_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_cnt_q <= CNT_W'(`PCC_RST_COUNT);
    end else if (rx_cell_done_i) begin
      rx_cnt_q <= rx_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_cnt_q <= CNT_W'(`PCC_RST_COUNT);
    end else if (tx_cell_done_i) begin
      tx_cnt_q <= tx_cnt_q + CNT_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // subport configuration

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_subport_width_o <= `PCC_RST_WIDTH;
    end else if (wr_cfg2) begin
      rx_subport_width_o <= req_i.wdata[2:0];
    end
  end

  logic [4:0] is_subport_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_subport_width_o <= `PCC_RST_WIDTH;
      is_subport_q <= `PCC_RST_SUBPORT;
    end else if (wr_cfg1) begin
      tx_subport_width_o <= req_i.wdata[7:5];
      is_subport_q <= req_i.wdata[4:0];
    end
  end

  logic [2:0] tx_bit_loc_q;
  logic [2:0] rx_bit_loc_q;

  // byte locations load from straps once, then only when unlocked
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_byte_loc_o <= 3'h0;
      tx_bit_loc_q <= `PCC_RST_BIT_LOC;
    end else if (strap_load) begin
      tx_byte_loc_o <= strap_tx_loc_s;
    end else if (wr_txpos) begin
      tx_bit_loc_q <= req_i.wdata[5:3];
      if (override_q) begin
        tx_byte_loc_o <= req_i.wdata[2:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_byte_loc_o <= 3'h0;
      rx_bit_loc_q <= `PCC_RST_BIT_LOC;
    end else if (strap_load) begin
      rx_byte_loc_o <= strap_rx_loc_s;
    end else if (wr_rxpos) begin
      rx_bit_loc_q <= req_i.wdata[5:3];
      if (override_q) begin
        rx_byte_loc_o <= req_i.wdata[2:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path

  logic [7:0] rmux;

  // counters narrower than 32 bits read back zero-extended
  logic [31:0] rx_cnt_rd;
  logic [31:0] tx_cnt_rd;
  assign rx_cnt_rd = 32'(rx_cnt_q);
  assign tx_cnt_rd = 32'(tx_cnt_q);

  always_comb begin
    rmux = 8'h00;
    case (req_i.addr)
      `PCC_ADDR_PIN_CTRL: rmux = {ee_din_q, ee_dout_sw_q, ee_cs_n_sw_q, ee_clk_sw_q,
                                  ee_mux_q, strap_q, override_q};
      `PCC_ADDR_RX_CNT_B3: rmux = rx_cnt_rd[31:24];
      `PCC_ADDR_RX_CNT_B2: rmux = rx_cnt_rd[23:16];
      `PCC_ADDR_RX_CNT_B1: rmux = rx_cnt_rd[15:8];
      `PCC_ADDR_RX_CNT_B0: rmux = rx_cnt_rd[7:0];
      `PCC_ADDR_TX_CNT_B3: rmux = tx_cnt_rd[31:24];
      `PCC_ADDR_TX_CNT_B2: rmux = tx_cnt_rd[23:16];
      `PCC_ADDR_TX_CNT_B1: rmux = tx_cnt_rd[15:8];
      `PCC_ADDR_TX_CNT_B0: rmux = tx_cnt_rd[7:0];
      `PCC_ADDR_RX_SUBPORT_CFG2: rmux = {5'h00, rx_subport_width_o};
      `PCC_ADDR_SUBPORT_CFG1: rmux = {tx_subport_width_o, is_subport_q};
      `PCC_ADDR_TX_SUBPORT_POS: rmux = {2'b00, tx_bit_loc_q, tx_byte_loc_o};
      `PCC_ADDR_RX_SUBPORT_POS: rmux = {2'b00, rx_bit_loc_q, rx_byte_loc_o};
      default: rmux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o <= req_i.rd ? rmux : 8'h00;
      rvalid_o <= req_i.rd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  property p_lock;
    @(posedge clk_i) disable iff (!rstn_i)
    (wr_txpos && !override_q && !strap_load) |=> $stable(tx_byte_loc_o);
  endproperty
  a_lock: assert property (p_lock) else $error("locked byte location changed");

  property p_strap1;
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(strap_s[0]) |=> strap_q[0];
  endproperty
  a_strap1: assert property (p_strap1) else $error("first strap not mirrored");

  property p_strap2;
    @(posedge clk_i) disable iff (!rstn_i)
    $fell(strap_s[1]) |=> !strap_q[1];
  endproperty
  a_strap2: assert property (p_strap2) else $error("second strap not mirrored");

  property p_sw_clk;
    @(posedge clk_i) disable iff (!rstn_i)
    (ee_mux_q && $stable(ee_mux_q)) |=> (ee_clk_o == $past(ee_clk_sw_q));
  endproperty
  a_sw_clk: assert property (p_sw_clk) else $error("eeprom clock not from software");

  property p_sw_cs;
    @(posedge clk_i) disable iff (!rstn_i)
    ee_mux_q |=> (ee_cs_n_o == $past(ee_cs_n_sw_q));
  endproperty
  a_sw_cs: assert property (p_sw_cs) else $error("eeprom select not from software");

  property p_loader;
    @(posedge clk_i) disable iff (!rstn_i)
    !ee_mux_q |=> (ee_dout_o == $past(loader_ee_i.dout));
  endproperty
  a_loader: assert property (p_loader) else $error("eeprom data not from loader");

  property p_rx_inc;
    @(posedge clk_i) disable iff (!rstn_i)
    rx_cell_done_i |=> (rx_cnt_q == $past(rx_cnt_q) + CNT_W'(1));
  endproperty
  a_rx_inc: assert property (p_rx_inc) else $error("rx count not advanced");

  property p_tx_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    !tx_cell_done_i |=> $stable(tx_cnt_q);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx count moved without cell");

  property p_width;
    @(posedge clk_i) disable iff (!rstn_i)
    wr_cfg2 |=> (rx_subport_width_o == $past(req_i.wdata[2:0]));
  endproperty
  a_width: assert property (p_width) else $error("rx width not written");

endmodule // pcc_regs

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pcc_params.svh"

module tb_top;
  localparam int CW = 8;
  logic clk_i;
  logic rstn_i;
  pcc_pkg::pcc_reg_req_t req_i;
  pcc_pkg::pcc_ee_drive_t loader_ee_i;
  logic [7:0] rdata_o;
  logic rvalid_o;
  logic strap_input_first_i;
  logic strap_input_second_i;
  logic [2:0] strap_tx_byte_loc_i;
  logic [2:0] strap_rx_byte_loc_i;
  logic rx_cell_done_i;
  logic tx_cell_done_i;
  logic ee_din_i;
  logic loader_ee_din_o;
  logic ee_clk_o;
  logic ee_cs_n_o;
  logic ee_dout_o;
  logic [2:0] rx_subport_width_o;
  logic [2:0] tx_subport_width_o;
  logic [2:0] tx_byte_loc_o;
  logic [2:0] rx_byte_loc_o;
  int err_count;
  int n_tests;
  logic [7:0] exp_q[$];
  string name_q[$];
  logic [31:0] rng_q;
  logic [31:0] rxc;
  logic [31:0] txc;
  logic [31:0] v;

  pcc_regs #(.CNT_W(CW)) i_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .strap_input_first_i(strap_input_first_i), .strap_input_second_i(strap_input_second_i),
    .strap_tx_byte_loc_i(strap_tx_byte_loc_i), .strap_rx_byte_loc_i(strap_rx_byte_loc_i),
    .rx_cell_done_i(rx_cell_done_i), .tx_cell_done_i(tx_cell_done_i),
    .loader_ee_i(loader_ee_i), .loader_ee_din_o(loader_ee_din_o), .ee_clk_o(ee_clk_o),
    .ee_cs_n_o(ee_cs_n_o), .ee_dout_o(ee_dout_o), .ee_din_i(ee_din_i),
    .rx_subport_width_o(rx_subport_width_o), .tx_subport_width_o(tx_subport_width_o),
    .tx_byte_loc_o(tx_byte_loc_o), .rx_byte_loc_o(rx_byte_loc_o)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rng_q ^= rng_q << 13;
    rng_q ^= rng_q >> 17;
    rng_q ^= rng_q << 5;
    return rng_q;
  endfunction

  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] e);
    n_tests++;
    if (got !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req_i <= '0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
    exp_q.push_back(e);
    name_q.push_back(n);
    req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_i <= '0;
    @(posedge clk_i);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // read results are compared as they appear
  always @(posedge clk_i) begin
    if (rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("[ERR] rvalid expected none seen 1");
      end else begin
        chk(name_q.pop_front(), rdata_o, exp_q.pop_front());
      end
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #100_000;
    err_count++;
    final_report();
  end

  initial begin
    err_count = 0;
    n_tests = 0;
    rng_q = 32'h0e5b_fa68;
    rstn_i = 1'b0;
    req_i = '0;
    loader_ee_i = '{clk: 1'b0, cs_n: 1'b1, dout: 1'b0};
    strap_input_first_i = 1'b0;
    strap_input_second_i = 1'b0;
    strap_tx_byte_loc_i = 3'h2;
    strap_rx_byte_loc_i = 3'h6;
    rx_cell_done_i = 1'b0;
    tx_cell_done_i = 1'b0;
    ee_din_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(`PCC_ADDR_PIN_CTRL, 8'h00, "pin_ctrl_rst");
    rd(`PCC_ADDR_RX_SUBPORT_CFG2, 8'h05, "rx_width_rst");
    chk("tx_width_rst", {5'h00, tx_subport_width_o}, 8'h05);
    chk("tx_loc_strap", {5'h00, tx_byte_loc_o}, 8'h02);
    chk("rx_loc_strap", {5'h00, rx_byte_loc_o}, 8'h06);
    for (int k = 0; k < 8; k++) begin
      rd(16'h801b + 16'(k), 8'h00, "count_rst");
    end
    $display("test reset done");

    // levels walk 1,2,3,0,1,2 so both pins rise and fall
    for (int k = 1; k < 7; k++) begin
      v = k % 4;
      strap_input_first_i <= v[0];
      strap_input_second_i <= v[1];
      repeat (10) @(posedge clk_i);
      rd(`PCC_ADDR_PIN_CTRL, {5'h00, v[1], v[0], 1'b0}, "strap_mirror");
    end
    $display("test straps done");

    wr(`PCC_ADDR_TX_SUBPORT_POS, 8'h07);
    wr(`PCC_ADDR_RX_SUBPORT_POS, 8'h01);
    chk("tx_loc_locked", {5'h00, tx_byte_loc_o}, 8'h02);
    chk("rx_loc_locked", {5'h00, rx_byte_loc_o}, 8'h06);
    wr(`PCC_ADDR_PIN_CTRL, 8'h01);
    wr(`PCC_ADDR_TX_SUBPORT_POS, 8'h07);
    wr(`PCC_ADDR_RX_SUBPORT_POS, 8'h01);
    chk("tx_loc_open", {5'h00, tx_byte_loc_o}, 8'h07);
    chk("rx_loc_open", {5'h00, rx_byte_loc_o}, 8'h01);
    $display("test unlock done");

    v = rnd();
    wr(`PCC_ADDR_RX_SUBPORT_CFG2, {5'h00, v[2:0]});
    rd(`PCC_ADDR_RX_SUBPORT_CFG2, {5'h00, v[2:0]}, "rx_width");
    chk("rx_width_out", {5'h00, rx_subport_width_o}, {5'h00, v[2:0]});
    wr(`PCC_ADDR_SUBPORT_CFG1, {v[7:5], 5'h00});
    chk("tx_width_out", {5'h00, tx_subport_width_o}, {5'h00, v[7:5]});
    $display("test widths done");

    // odd passes hand the pins to software, even ones to the loader
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      loader_ee_i <= v[10:8];
      ee_din_i <= v[11];
      wr(`PCC_ADDR_PIN_CTRL, {v[7:4], i[0], 3'h1});
      repeat (6) @(posedge clk_i);
      chk("ee_clk", {7'h00, ee_clk_o}, {7'h00, i[0] ? v[4] : v[10]});
      chk("ee_cs_n", {7'h00, ee_cs_n_o}, {7'h00, i[0] ? v[5] : v[9]});
      chk("ee_dout", {7'h00, ee_dout_o}, {7'h00, i[0] ? v[6] : v[8]});
      chk("loader_din", {7'h00, loader_ee_din_o}, {7'h00, v[11]});
      rd(`PCC_ADDR_PIN_CTRL, {i[0] & v[11], v[6:4], i[0], 3'h5}, "ee_readback");
    end
    $display("test eeprom done");

    rxc = 260 + (rnd() % 16);
    txc = 0;
    for (int i = 0; i < int'(rxc); i++) begin
      v = rnd();
      rx_cell_done_i <= 1'b1;
      tx_cell_done_i <= v[0];
      txc += v[0];
      @(posedge clk_i);
      rx_cell_done_i <= 1'b0;
      tx_cell_done_i <= 1'b0;
      @(posedge clk_i);
    end
    wr(`PCC_ADDR_RX_CNT_B0, 8'hff);
    rxc &= (32'h1 << CW) - 1;
    txc &= (32'h1 << CW) - 1;
    for (int k = 0; k < 8; k++) begin
      v = (k < 4) ? rxc : txc;
      v = v >> (8 * (3 - k % 4));
      rd(16'h801b + 16'(k), v[7:0], "cell_count");
    end
    rd(16'h8030, 8'h00, "unmapped");
    $display("test counters done");

    repeat (4) @(posedge clk_i);
    chk("pending_reads", 8'(exp_q.size()), 8'h00);
    final_report();
  end
endmodule // tb_top

`default_nettype wire
